// ==== src/two_wire_defines.svh ====
// Register map, reset values, status codes and timing for the two-wire master
`ifndef TWO_WIRE_DEFINES_SVH
`define TWO_WIRE_DEFINES_SVH

`define TW_ADDR_W 4
`define TW_IDX_CTRL 2'h0
`define TW_IDX_STAT 2'h1
`define TW_IDX_DATA 2'h2

`define TW_CTRL_RESET 8'h00
`define TW_STAT_PRESC_RESET 2'h0
`define TW_DATA_RESET 8'hff

// Status codes kept as bits 7:3, so 0x08 is 5'h01
`define TW_CODE_START 5'h01
`define TW_CODE_RSTART 5'h02
`define TW_CODE_ADDR_ACK 5'h03
`define TW_CODE_ADDR_NACK 5'h04
`define TW_CODE_DATA_ACK 5'h05
`define TW_CODE_DATA_NACK 5'h06
`define TW_CODE_LOST 5'h07
`define TW_CODE_RADDR_ACK 5'h08
`define TW_CODE_RADDR_NACK 5'h09
`define TW_CODE_NONE 5'h1f

`define TW_ACK_BIT 4'h8
`define TW_RESP_OKAY 2'h0
`define TW_RESP_SLVERR 2'h2

`define TW_CLK_NS 40
`define TW_HALF_NS 5000
`define TW_HALF_CYC ((`TW_HALF_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)
`define TW_TMR_W 8

`endif

// ==== src/two_wire_pkg.sv ====
// Types shared by the two-wire master files
package two_wire_pkg;

	typedef struct packed {
		logic flag;
		logic ack_enable;
		logic start_request;
		logic stop_request;
		logic write_collision_flag;
		logic enable;
		logic unused;
		logic event_irq_enable;
	} link_ctrl_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_WAIT_FREE = 4'h1,
		ST_START = 4'h2,
		ST_HOLD = 4'h3,
		ST_BIT_LOW = 4'h4,
		ST_BIT_HIGH = 4'h5,
		ST_STOP_LOW = 4'h6,
		ST_STOP_HIGH = 4'h7,
		ST_STOP_END = 4'h8,
		ST_RS_LOW = 4'h9,
		ST_RS_HIGH = 4'ha
	} tw_state_t;

endpackage

// ==== src/sync_two_ff.sv ====
// Two-flop synchroniser for a pin level
`timescale 1ns/1ps
module sync_two_ff
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Level in and out
	input wire logic din,
	output logic dout
);
	logic meta_reg;

	// Idle bus level is high
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_reg <= 1'b1;
			dout <= 1'b1;
		end
		else
		begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule

// ==== src/phase_timer.sv ====
// Down counter that times one bus phase
`timescale 1ns/1ps
module phase_timer
#(
	parameter int W = 8,
	parameter logic [W-1:0] LEN = 8'h01
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic restart,
	output logic done
);
	logic [W-1:0] cnt_reg;

	// Plain compare: a restart term here would loop back through the caller's next state
	assign done = (cnt_reg == '0);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_reg <= '0;
		else if (restart)
			cnt_reg <= LEN - 1'b1;
		else if (cnt_reg != '0)
			cnt_reg <= cnt_reg - 1'b1;
	end
endmodule

// ==== src/two_wire_master_transmitter.sv ====
// Two-wire master transmitter with AXI4-Lite register access
`timescale 1ns/1ps
`include "two_wire_defines.svh"
module two_wire_master_transmitter
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [`TW_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [`TW_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Bus pins, open drain
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Mode to the rest of the unit
	output logic master_transmit_mode,
	output logic master_receive_mode
);
	two_wire_pkg::link_ctrl_t ctrl_reg, wd;
	two_wire_pkg::tw_state_t state_reg, state_next;
	logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
	logic [`TW_ADDR_W-1:0] aw_addr_reg;
	logic [7:0] w_data_reg, data_reg, tx_reg, tx_next, rdata_reg;
	logic w_strb_reg;
	logic [1:0] bresp_reg, rresp_reg, presc_reg;
	logic [4:0] code_reg, code_next;
	logic [3:0] bit_cnt_reg, bit_cnt_next;
	logic scl_low_reg, sda_low_reg, scl_low_next, sda_low_next;
	logic lost_reg, lost_next, repeat_reg, repeat_next, pend_reg, pend_next;
	logic rd_dir_reg, rd_dir_next, is_addr_reg, is_addr_next;
	logic xmit_mode_reg, recv_mode_reg, xmit_mode_next, recv_mode_next;
	logic flag_set, stop_clr, busy_reg, scl_s, sda_s, scl_q, sda_q, tmr_done;

	sync_two_ff u_scl_sync (.aclk(aclk), .aresetn(aresetn), .din(scl_i), .dout(scl_s));
	sync_two_ff u_sda_sync (.aclk(aclk), .aresetn(aresetn), .din(sda_i), .dout(sda_s));

	// Register slave decode
	wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	wire [1:0] wr_idx = aw_addr_reg[3:2];
	wire wr_mapped = (wr_idx != 2'h3);
	wire wr_ok = do_write && wr_mapped && w_strb_reg;
	wire ctrl_wr = wr_ok && (wr_idx == `TW_IDX_CTRL);
	wire stat_wr = wr_ok && (wr_idx == `TW_IDX_STAT);
	wire data_wr = wr_ok && (wr_idx == `TW_IDX_DATA);
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire [1:0] rd_idx = s_axi_araddr[3:2];
	wire rd_mapped = (rd_idx != 2'h3);
	wire [7:0] stat_val = {code_reg, 1'b0, presc_reg};
	wire [7:0] rd_mux = (rd_idx == `TW_IDX_CTRL) ? ctrl_reg :
		(rd_idx == `TW_IDX_STAT) ? stat_val :
		(rd_idx == `TW_IDX_DATA) ? data_reg : 8'h00;
	assign wd = w_data_reg;
	wire go = ctrl_wr && wd.flag && wd.enable;
	wire hold_go = go && (state_reg == two_wire_pkg::ST_HOLD) && ctrl_reg.flag;
	// Enable as it stands after this edge, so the write that sets it can also start
	wire en_now = ctrl_wr ? wd.enable : ctrl_reg.enable;

	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = {24'h000000, rdata_reg};
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_low_reg;
	assign sda_oe = sda_low_reg;
	assign master_transmit_mode = xmit_mode_reg;
	assign master_receive_mode = recv_mode_reg;

	// Bus line watch
	wire start_det = scl_q && scl_s && sda_q && !sda_s;
	wire stop_det = scl_q && scl_s && !sda_q && sda_s;
	wire high_wait = (state_reg == two_wire_pkg::ST_BIT_HIGH) || (state_reg == two_wire_pkg::ST_STOP_HIGH) ||
		(state_reg == two_wire_pkg::ST_RS_HIGH);
	// Slave stretching holds the phase until the line is seen high
	wire tmr_restart = (state_next != state_reg) || (high_wait && !scl_s);
	wire ack_seen = !sda_s;
	wire bit_one = tx_reg[7];

	phase_timer #(.W(`TW_TMR_W), .LEN(`TW_TMR_W'(`TW_HALF_CYC))) u_timer
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(tmr_restart),
		.done(tmr_done)
	);

	always_comb
	begin
		state_next = state_reg;
		scl_low_next = scl_low_reg;
		sda_low_next = sda_low_reg;
		code_next = code_reg;
		tx_next = tx_reg;
		bit_cnt_next = bit_cnt_reg;
		lost_next = lost_reg;
		repeat_next = repeat_reg;
		pend_next = pend_reg;
		rd_dir_next = rd_dir_reg;
		is_addr_next = is_addr_reg;
		xmit_mode_next = xmit_mode_reg;
		recv_mode_next = recv_mode_reg;
		flag_set = 1'b0;
		stop_clr = 1'b0;
		unique case (state_reg)
			two_wire_pkg::ST_IDLE:
			begin
				scl_low_next = 1'b0;
				sda_low_next = 1'b0;
				if (go && wd.start_request && !wd.stop_request)
				begin
					state_next = two_wire_pkg::ST_WAIT_FREE;
					repeat_next = 1'b0;
				end
			end
			two_wire_pkg::ST_WAIT_FREE:
				if (!busy_reg && scl_s && sda_s)
					state_next = two_wire_pkg::ST_START;
			two_wire_pkg::ST_START:
			begin
				sda_low_next = 1'b1;
				if (tmr_done)
				begin
					state_next = two_wire_pkg::ST_HOLD;
					scl_low_next = 1'b1;
					flag_set = 1'b1;
					code_next = repeat_reg ? `TW_CODE_RSTART : `TW_CODE_START;
				end
			end
			two_wire_pkg::ST_HOLD:
				if (hold_go)
				begin
					if (lost_reg)
					begin
						lost_next = 1'b0;
						repeat_next = 1'b0;
						state_next = wd.start_request ? two_wire_pkg::ST_WAIT_FREE : two_wire_pkg::ST_IDLE;
					end
					else if (wd.stop_request)
					begin
						pend_next = wd.start_request;
						state_next = two_wire_pkg::ST_STOP_LOW;
					end
					else if (wd.start_request)
						state_next = two_wire_pkg::ST_RS_LOW;
					else
					begin
						state_next = two_wire_pkg::ST_BIT_LOW;
						tx_next = data_reg;
						bit_cnt_next = 4'h0;
						is_addr_next = (code_reg == `TW_CODE_START) || (code_reg == `TW_CODE_RSTART);
						if (is_addr_next)
							rd_dir_next = data_reg[0];
					end
				end
			two_wire_pkg::ST_BIT_LOW:
			begin
				scl_low_next = 1'b1;
				sda_low_next = (bit_cnt_reg == `TW_ACK_BIT) ? 1'b0 : !bit_one;
				if (tmr_done)
				begin
					state_next = two_wire_pkg::ST_BIT_HIGH;
					scl_low_next = 1'b0;
				end
			end
			two_wire_pkg::ST_BIT_HIGH:
				if (tmr_done)
				begin
					if (bit_cnt_reg != `TW_ACK_BIT && bit_one && !sda_s)
					begin
						state_next = two_wire_pkg::ST_HOLD;
						sda_low_next = 1'b0;
						lost_next = 1'b1;
						flag_set = 1'b1;
						code_next = `TW_CODE_LOST;
						xmit_mode_next = 1'b0;
					end
					else if (bit_cnt_reg != `TW_ACK_BIT)
					begin
						state_next = two_wire_pkg::ST_BIT_LOW;
						scl_low_next = 1'b1;
						tx_next = {tx_reg[6:0], 1'b1};
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end
					else
					begin
						state_next = two_wire_pkg::ST_HOLD;
						scl_low_next = 1'b1;
						flag_set = 1'b1;
						if (is_addr_reg && rd_dir_reg)
						begin
							code_next = ack_seen ? `TW_CODE_RADDR_ACK : `TW_CODE_RADDR_NACK;
							xmit_mode_next = 1'b0;
							recv_mode_next = 1'b1;
						end
						else if (is_addr_reg)
						begin
							code_next = ack_seen ? `TW_CODE_ADDR_ACK : `TW_CODE_ADDR_NACK;
							xmit_mode_next = 1'b1;
							recv_mode_next = 1'b0;
						end
						else
							code_next = ack_seen ? `TW_CODE_DATA_ACK : `TW_CODE_DATA_NACK;
					end
				end
			two_wire_pkg::ST_STOP_LOW:
			begin
				sda_low_next = 1'b1;
				if (tmr_done)
				begin
					state_next = two_wire_pkg::ST_STOP_HIGH;
					scl_low_next = 1'b0;
				end
			end
			two_wire_pkg::ST_STOP_HIGH:
				if (tmr_done)
				begin
					state_next = two_wire_pkg::ST_STOP_END;
					sda_low_next = 1'b0;
				end
			two_wire_pkg::ST_STOP_END:
				if (tmr_done)
				begin
					stop_clr = 1'b1;
					xmit_mode_next = 1'b0;
					recv_mode_next = 1'b0;
					pend_next = 1'b0;
					repeat_next = 1'b0;
					code_next = `TW_CODE_NONE;
					state_next = pend_reg ? two_wire_pkg::ST_WAIT_FREE : two_wire_pkg::ST_IDLE;
				end
			two_wire_pkg::ST_RS_LOW:
			begin
				sda_low_next = 1'b0;
				if (tmr_done)
				begin
					state_next = two_wire_pkg::ST_RS_HIGH;
					scl_low_next = 1'b0;
				end
			end
			two_wire_pkg::ST_RS_HIGH:
				if (tmr_done)
				begin
					state_next = two_wire_pkg::ST_START;
					repeat_next = 1'b1;
				end
			default:
				state_next = two_wire_pkg::ST_IDLE;
		endcase
		// Disable drops the bus at once
		if (!en_now)
		begin
			state_next = two_wire_pkg::ST_IDLE;
			scl_low_next = 1'b0;
			sda_low_next = 1'b0;
			xmit_mode_next = 1'b0;
			recv_mode_next = 1'b0;
			lost_next = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= two_wire_pkg::ST_IDLE;
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			code_reg <= `TW_CODE_NONE;
			tx_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			{lost_reg, repeat_reg, pend_reg, rd_dir_reg, is_addr_reg, xmit_mode_reg, recv_mode_reg} <= 7'h00;
			{scl_q, sda_q, busy_reg} <= 3'h6;
		end
		else
		begin
			state_reg <= state_next;
			scl_low_reg <= scl_low_next;
			sda_low_reg <= sda_low_next;
			code_reg <= code_next;
			tx_reg <= tx_next;
			bit_cnt_reg <= bit_cnt_next;
			{lost_reg, repeat_reg, pend_reg} <= {lost_next, repeat_next, pend_next};
			{rd_dir_reg, is_addr_reg, xmit_mode_reg, recv_mode_reg} <= {rd_dir_next, is_addr_next, xmit_mode_next,
				recv_mode_next};
			{scl_q, sda_q} <= {scl_s, sda_s};
			busy_reg <= start_det ? 1'b1 : (stop_det ? 1'b0 : busy_reg);
		end
	end

	// Control, status and data registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_reg <= `TW_CTRL_RESET;
			data_reg <= `TW_DATA_RESET;
			presc_reg <= `TW_STAT_PRESC_RESET;
		end
		else
		begin
			ctrl_reg.flag <= flag_set || (ctrl_reg.flag && !(ctrl_wr && wd.flag));
			if (ctrl_wr)
			begin
				ctrl_reg.ack_enable <= wd.ack_enable;
				ctrl_reg.start_request <= wd.start_request;
				ctrl_reg.enable <= wd.enable;
				ctrl_reg.event_irq_enable <= wd.event_irq_enable;
			end
			// a fresh write beats the self clear
			ctrl_reg.stop_request <= ctrl_wr ? wd.stop_request : (ctrl_reg.stop_request && !stop_clr);
			if (data_wr)
				ctrl_reg.write_collision_flag <= !ctrl_reg.flag;
			if (data_wr && ctrl_reg.flag)
				data_reg <= w_data_reg;
			if (stat_wr)
				presc_reg <= w_data_reg[1:0];
		end
	end

	// AXI4-Lite handshakes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg, w_strb_reg} <= 5'h00;
			aw_addr_reg <= '0;
			w_data_reg <= 8'h00;
			{bresp_reg, rresp_reg} <= 4'h0;
			rdata_reg <= 8'h00;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
				{aw_held_reg, aw_addr_reg} <= {1'b1, s_axi_awaddr};
			if (s_axi_wvalid && s_axi_wready)
				{w_held_reg, w_data_reg, w_strb_reg} <= {1'b1, s_axi_wdata[7:0], s_axi_wstrb[0]};
			if (do_write)
			begin
				{aw_held_reg, w_held_reg, bvalid_reg} <= 3'h1;
				bresp_reg <= wr_mapped ? `TW_RESP_OKAY : `TW_RESP_SLVERR;
			end
			else if (bvalid_reg && s_axi_bready)
				bvalid_reg <= 1'b0;
			if (rd_take)
			begin
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_mux;
				rresp_reg <= rd_mapped ? `TW_RESP_OKAY : `TW_RESP_SLVERR;
			end
			else if (rvalid_reg && s_axi_rready)
				rvalid_reg <= 1'b0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_start_done;
		state_reg == two_wire_pkg::ST_START && tmr_done && en_now;
	endsequence
	sequence s_ack_done;
		state_reg == two_wire_pkg::ST_BIT_HIGH && tmr_done && bit_cnt_reg == `TW_ACK_BIT && en_now;
	endsequence

	a_start_status: assert property (s_start_done |=> ctrl_reg.flag && scl_low_reg &&
		(code_reg == `TW_CODE_START || code_reg == `TW_CODE_RSTART))
		else $error("start not reported");
	a_flag_clear: assert property (hold_go && !flag_set |=> !ctrl_reg.flag)
		else $error("flag not cleared");
	a_hold_quiet: assert property (state_reg == two_wire_pkg::ST_HOLD && !hold_go && en_now
		|=> state_reg == two_wire_pkg::ST_HOLD && $stable(scl_low_reg))
		else $error("bus moved while suspended");
	a_wcol_set: assert property (data_wr && !ctrl_reg.flag |=> ctrl_reg.write_collision_flag && $stable(data_reg))
		else $error("collision not flagged");
	a_wcol_clear: assert property (data_wr && ctrl_reg.flag |=> !ctrl_reg.write_collision_flag)
		else $error("collision not cleared");
	a_addr_status: assert property (s_ack_done ##0 (is_addr_reg && !rd_dir_reg) |=>
		ctrl_reg.flag && xmit_mode_reg && code_reg == ($past(sda_s) ? `TW_CODE_ADDR_NACK : `TW_CODE_ADDR_ACK))
		else $error("address status wrong");
	a_data_status: assert property (s_ack_done ##0 !is_addr_reg |=>
		ctrl_reg.flag && code_reg == ($past(sda_s) ? `TW_CODE_DATA_NACK : `TW_CODE_DATA_ACK))
		else $error("data status wrong");
	a_stop_clear: assert property (stop_clr && !ctrl_wr |=> !ctrl_reg.stop_request && !scl_oe && !sda_oe)
		else $error("stop request kept");
	a_lost_release: assert property (lost_reg && state_reg == two_wire_pkg::ST_HOLD |-> !sda_oe &&
		code_reg == `TW_CODE_LOST)
		else $error("bus held after loss");
	a_free_wait: assert property (state_reg == two_wire_pkg::ST_WAIT_FREE && busy_reg && en_now
		|=> state_reg == two_wire_pkg::ST_WAIT_FREE && !sda_oe)
		else $error("start on busy bus");
	a_read_mode: assert property (s_ack_done ##0 (is_addr_reg && rd_dir_reg) |=> recv_mode_reg && !xmit_mode_reg)
		else $error("no receive mode");
endmodule

// ==== verif/slave_receiver_model.sv ====
// Slave receiver on the two-wire bus: acks, nacks and stretches the clock
`timescale 1ns/1ps
module slave_receiver_model
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus levels and pulls
	input wire logic scl,
	input wire logic sda,
	output logic scl_oe,
	output logic sda_oe,
	// Behaviour and result
	input wire logic nack,
	input wire logic stretch,
	output logic [7:0] last_byte
);
	logic scl_reg, sda_reg;
	logic [3:0] nbit_reg;
	logic [7:0] shift_reg;
	logic [9:0] hold_reg;
	wire rise = scl && !scl_reg;
	wire fall = !scl && scl_reg;
	// START or STOP restarts the byte
	wire frame = scl && scl_reg && (sda != sda_reg);
	// Released lines go to the pull-up level
	assign scl_oe = (hold_reg != 10'h000);
	always_ff @(posedge aclk)
	begin
		scl_reg <= scl;
		sda_reg <= sda;
		if (!aresetn || frame)
		begin
			nbit_reg <= 4'h0;
			sda_oe <= 1'b0;
			hold_reg <= 10'h000;
			if (!aresetn)
				last_byte <= 8'h00;
		end
		else
		begin
			if (hold_reg != 10'h000)
				hold_reg <= hold_reg - 10'h001;
			if (rise)
				nbit_reg <= nbit_reg + 4'h1;
			if (rise && nbit_reg < 4'h8)
				shift_reg <= {shift_reg[6:0], sda};
			if (rise && nbit_reg == 4'h7)
				last_byte <= {shift_reg[6:0], sda};
			// answer on the ninth bit, slow when asked
			if (fall && nbit_reg == 4'h8)
			begin
				sda_oe <= !nack;
				hold_reg <= stretch ? 10'h190 : 10'h000;
			end
			if (fall && nbit_reg == 4'h9)
			begin
				sda_oe <= 1'b0;
				nbit_reg <= 4'h0;
			end
		end
	end
endmodule

// ==== verif/two_wire_master_transmitter_tb.sv ====
// Self-checking bench for the two-wire master transmitter
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end
module two_wire_master_transmitter_tb;
	typedef struct packed {
		logic hasd;
		logic [7:0] data;
		logic [7:0] ctrl;
		logic nack;
		logic stretch;
		logic [7:0] code;
		logic [1:0] modes;
	} row_t;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, nack, stretch, pull;
	logic [3:0] awaddr, araddr;
	logic [31:0] wdata, rd;
	logic [1:0] rr, br, lines_q;
	wire awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, xmit_mode, recv_mode, s_scl_oe, s_sda_oe;
	wire [1:0] rresp, bresp;
	wire [31:0] rdata;
	wire [7:0] s_byte;
	int n_mismatch, checks;
	row_t rows [10];
	// Open-drain lines with pull-ups
	wire scl = !(scl_oe || s_scl_oe);
	wire sda = !(sda_oe || s_sda_oe || pull);

	two_wire_master_transmitter uut
	(
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
		.master_transmit_mode(xmit_mode), .master_receive_mode(recv_mode)
	);

	slave_receiver_model slave
	(
		.aclk(aclk), .aresetn(aresetn), .scl(scl), .sda(sda), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe),
		.nack(nack), .stretch(stretch), .last_byte(s_byte)
	);

	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task print_verdict;
		$display("Mismatches %0d, checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task tmo(input int n, input int lim);
		if (n >= lim)
		begin
			n_mismatch++;
			$display("ERROR %0t: wait timed out", $time);
			print_verdict;
		end
	endtask

	task wr(input logic [3:0] a, input logic [7:0] d);
		int n;
		logic pa, pw, ta, tw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50 && (pa || pw); n++)
		begin
			@(negedge aclk);
			ta = pa && awready;
			tw = pw && wready;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		tmo(n, 50);
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			br = bresp;
			if (bvalid)
				break;
		end
		tmo(n, 50);
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task rdr(input logic [3:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			if (arready)
				break;
		end
		tmo(n, 50);
		@(posedge aclk);
		arvalid <= 1'b0;
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			if (rvalid)
				break;
		end
		tmo(n, 50);
		rd = rdata;
		rr = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// Polled, since the block has no interrupt line
	task wait_flag;
		int n;
		for (n = 0; n < 3000; n++)
		begin
			rdr(4'h0);
			if (rd[7])
				break;
		end
		tmo(n, 3000);
	endtask

	task go(input logic [7:0] c);
		wr(4'h0, c);
		rdr(4'h0);
		`CHK(rd[7], 1'b0)
		wait_flag;
		rdr(4'h4);
	endtask

	initial
	begin
		int n;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, nack, stretch, pull} = 9'h000;
		{awaddr, araddr, wdata} = 40'h0000000000;
		n_mismatch = 0;
		checks = 0;
		// address first, enable kept set in every control value
		rows = '{
			'{1'b0, 8'h00, 8'ha4, 1'b0, 1'b0, 8'h08, 2'b00},
			'{1'b1, 8'ha0, 8'h84, 1'b0, 1'b0, 8'h18, 2'b10},
			'{1'b1, 8'h5a, 8'h84, 1'b0, 1'b1, 8'h28, 2'b10},
			'{1'b1, 8'h33, 8'h84, 1'b1, 1'b0, 8'h30, 2'b10},
			'{1'b1, 8'h96, 8'h84, 1'b0, 1'b0, 8'h28, 2'b10},
			'{1'b0, 8'h00, 8'ha4, 1'b0, 1'b0, 8'h10, 2'b10},
			'{1'b1, 8'ha1, 8'h84, 1'b0, 1'b0, 8'h40, 2'b01},
			'{1'b0, 8'h00, 8'hb4, 1'b0, 1'b0, 8'h08, 2'b00},
			'{1'b1, 8'ha0, 8'h84, 1'b1, 1'b0, 8'h20, 2'b10},
			'{1'b1, 8'h11, 8'h84, 1'b0, 1'b0, 8'h28, 2'b10}};
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		wr(4'h8, 8'h77);
		rdr(4'h0);
		`CHK(rd[3], 1'b1)
		rdr(4'h8);
		`CHK(rd[7:0], 8'hff)
		// Nonzero prescaler so every status compare needs its mask
		wr(4'h4, 8'h03);
		`CHK(br, 2'h0)
		for (int i = 0; i < 10; i++)
		begin
			if (rows[i].hasd)
				wr(4'h8, rows[i].data);
			nack <= rows[i].nack;
			stretch <= rows[i].stretch;
			go(rows[i].ctrl);
			`CHK(rd[7:0] & 8'hf8, rows[i].code)
			`CHK({xmit_mode, recv_mode}, rows[i].modes)
			if (rows[i].hasd)
				`CHK(s_byte, rows[i].data)
		end
		// Data write while a byte is on the wire
		wr(4'h0, 8'h84);
		wr(4'h8, 8'h66);
		wait_flag;
		rdr(4'h8);
		`CHK(rd[7:0], 8'h11)
		`CHK(s_byte, 8'h11)
		lines_q = {scl_oe, sda_oe};
		repeat (300) @(posedge aclk);
		`CHK({scl_oe, sda_oe}, lines_q)
		wr(4'h8, 8'h66);
		rdr(4'h0);
		`CHK(rd[3], 1'b0)
		wr(4'h0, 8'h94);
		for (n = 0; n < 200; n++)
		begin
			rdr(4'h0);
			if (!rd[4])
				break;
		end
		`CHK(rd[4], 1'b0)
		repeat (200) @(posedge aclk);
		`CHK({scl, sda, xmit_mode}, 3'b110)
		go(8'ha4);
		wr(4'h8, 8'hfe);
		pull <= 1'b1;
		go(8'h84);
		`CHK(rd[7:0] & 8'hf8, 8'h38)
		// Bus still held low by the rival, so no START yet
		wr(4'h0, 8'ha4);
		repeat (300) @(posedge aclk);
		`CHK(sda_oe, 1'b0)
		pull <= 1'b0;
		wait_flag;
		rdr(4'h4);
		`CHK(rd[7:0] & 8'hf8, 8'h08)
		`CHK(rd[1:0], 2'h3)
		wr(4'h8, 8'hff);
		pull <= 1'b1;
		go(8'h84);
		`CHK(rd[7:0] & 8'hf8, 8'h38)
		wr(4'h0, 8'h84);
		repeat (20) @(posedge aclk);
		`CHK({scl_oe, sda_oe, xmit_mode}, 3'b000)
		pull <= 1'b0;
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(4'h4);
		`CHK(rd[7:0], 8'hf8)
		rdr(4'h0);
		`CHK(rd[7:0], 8'h00)
		rdr(4'hc);
		`CHK(rr, 2'h2)
		wr(4'hc, 8'h55);
		`CHK(br, 2'h2)
		print_verdict;
	end
endmodule
